// ---- ddc_pkg.sv ----
// Constants, register map and helpers for the cascaded divider with duty balance
package ddc_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PRESC = 8'h04;
    localparam logic [7:0] ADDR_DIV1 = 8'h08;
    localparam logic [7:0] ADDR_DIV2 = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;

    // Control register fields
    localparam int CTRL_BAL_DIS = 0;
    localparam int CTRL_BYP1 = 1;
    localparam int CTRL_BYP2 = 2;
    localparam int CTRL_RUN = 3;
    localparam int CTRL_W = 4;
    localparam logic [3:0] CTRL_RST = 4'h6;

    // Prescaler select: values below PRESC_MIN or above PRESC_MAX mean unused
    localparam int PRESC_W = 3;
    localparam logic [2:0] PRESC_RST = 3'h1;
    localparam logic [2:0] PRESC_MIN = 3'h2;
    localparam logic [2:0] PRESC_MAX = 3'h6;

    // Stage count fields: high count in low nibble, low count in high nibble
    localparam int CNT_W = 4;
    localparam int FLD_N_LSB = 0;
    localparam int FLD_M_LSB = 4;
    localparam logic [7:0] DIV_RST = 8'h00;

    // Status register fields
    localparam int STAT_LVL = 0;
    localparam int STAT_OK = 1;
    localparam int STAT_DIV_LSB = 2;

    // Division limits and link period width
    localparam int PER_W = 13;
    localparam int DIV_MAX = 1024;
    localparam int NUM_STAGES = 3;

    // Division of one stage, one when bypassed
    function automatic logic [5:0] stage_div(input logic byp, input logic [3:0] n,
                                             input logic [3:0] m);
        stage_div = byp ? 6'h01 : ({2'h0, n} + {2'h0, m} + 6'h02);
    endfunction

endpackage

// ---- ddc_link_if.sv ----
// Link carrying clock ticks, level and period between divider stages
`timescale 1ns/1ps
`default_nettype none
interface ddc_link_if;
    import ddc_pkg::*;
    logic tick;                 // One-cycle pulse at each rising output edge
    logic level;                // Output waveform of the stage
    logic [PER_W-1:0] period;   // Output period in core clock cycles
    modport src (output tick, output level, output period);
    modport snk (input tick, input level, input period);
endinterface
`default_nettype wire

// ---- ddc_stage.sv ----
// One divider stage with high/low counts, bypass and duty balance stretch
`timescale 1ns/1ps
`default_nettype none
module ddc_stage
    import ddc_pkg::*;
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    // Configuration
    input wire logic balanceOn,
    input wire logic bypass,
    input wire logic [CNT_W-1:0] nHigh,
    input wire logic [CNT_W-1:0] mLow,
    // Links
    ddc_link_if.snk up,
    ddc_link_if.src dn,
    // Half-cycle extension in use on this stage
    output logic halfOn
);
    logic [4:0] cnt_q, cnt_d;           // Position inside the output period
    logic hi_q, hi_d;                   // Output level before retiming
    logic strOn_q, strOn_d;             // Fall is being held back
    logic [PER_W-1:0] str_q, str_d;     // Core cycles left in the hold
    logic tick_q, tick_d;               // Rising-edge pulse to the next stage
    logic neg_q, neg_d;                 // Copy of the level on the falling edge
    logic [4:0] divM1;                  // Division minus one
    logic ext;                          // Odd division with balance active
    logic [PER_W-1:0] extFull;          // Whole core cycles of half an input period

    // Division is high plus low fields plus two
    assign divM1 = {1'b0, nHigh} + {1'b0, mLow} + 5'h01;
    assign ext = balanceOn && !bypass && !divM1[0];
    assign extFull = up.period >> 1;
    // Odd input period leaves half a core cycle for the falling edge
    assign halfOn = ext && up.period[0];

    // Next-state: count input ticks, rise at wrap, fall after high count
    always_comb begin
        cnt_d = cnt_q;
        hi_d = hi_q;
        strOn_d = strOn_q;
        str_d = str_q;
        tick_d = 1'b0;
        if (!bypass) begin
            // Held fall expires after the stretch
            if (strOn_q) begin
                // A hold also ends when balance goes off, so no stale stretch survives
                if (str_q == '0 || !ext) begin
                    hi_d = 1'b0;
                    strOn_d = 1'b0;
                end else begin
                    str_d = str_q - 13'h0001;
                end
            end
            if (up.tick) begin
                if (cnt_q == divM1) begin
                    // Wrap: start a new period high
                    cnt_d = 5'h00;
                    hi_d = 1'b1;
                    tick_d = 1'b1;
                    strOn_d = 1'b0;
                end else begin
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == {1'b0, nHigh}) begin
                        // High count done; balance may stretch the fall
                        if (ext && extFull != '0) begin
                            strOn_d = 1'b1;
                            str_d = extFull - 13'h0001;
                        end else begin
                            hi_d = 1'b0;
                        end
                    end
                end
            end
        end
    end

    // Registers of the rising-edge side
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 5'h00;
            hi_q <= 1'b0;
            strOn_q <= 1'b0;
            str_q <= '0;
            tick_q <= 1'b0;
        end else if (clkEn) begin
            cnt_q <= cnt_d;
            hi_q <= hi_d;
            strOn_q <= strOn_d;
            str_q <= str_d;
            tick_q <= tick_d;
        end
    end

    // Opposite-edge copy gives the half-cycle retimed fall
    always_comb begin
        neg_d = hi_q;
    end

    always_ff @(negedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            neg_q <= 1'b0;
        end else if (clkEn) begin
            neg_q <= neg_d;
        end
    end

    // Bypass passes the upstream link straight on
    assign dn.tick = bypass ? up.tick : tick_q;
    assign dn.level = bypass ? up.level : (hi_q || (halfOn && neg_q));
    // Division is widened before the add, since a divide-by-32 overflows five bits
    assign dn.period = bypass ? up.period : PER_W'(up.period * ({8'h00, divM1} + 13'h0001));

    property p_bal_off_nostretch;
        @(posedge core_clk) disable iff (!arst_n)
        clkEn && !balanceOn && !bypass |-> !halfOn ##1 !strOn_q;
    endproperty
    a_bal_off_nostretch: assert property (p_bal_off_nostretch)
        else $error("stretch active with balance disabled");

    property p_rise_at_wrap;
        @(posedge core_clk) disable iff (!arst_n)
        clkEn && !bypass && up.tick && cnt_q == divM1 |=> hi_q && cnt_q == 5'h00;
    endproperty
    a_rise_at_wrap: assert property (p_rise_at_wrap)
        else $error("stage did not rise at period wrap");

    property p_plain_fall;
        @(posedge core_clk) disable iff (!arst_n)
        clkEn && !bypass && !ext && up.tick && cnt_q == {1'b0, nHigh} && cnt_q != divM1
        |=> !hi_q;
    endproperty
    a_plain_fall: assert property (p_plain_fall)
        else $error("stage did not fall after high count");

    property p_held_fall;
        @(posedge core_clk) disable iff (!arst_n)
        clkEn && ext && up.tick && cnt_q == {1'b0, nHigh} && extFull != '0
        |=> hi_q && strOn_q;
    endproperty
    a_held_fall: assert property (p_held_fall)
        else $error("odd balanced stage fell without stretch");
endmodule // ddc_stage
`default_nettype wire

// ---- ddc_top.sv ----
// Cascaded channel divider with duty balance and an AHB-Lite register slave
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module ddc_top
    import ddc_pkg::*;
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Divided clock to the output buffers
    output logic clkOut
);
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;      // Balance disable, bypasses, run
    logic [PRESC_W-1:0] presc_q, presc_d;   // Prescale select
    logic [7:0] div1_q, div1_d;             // Stage one counts
    logic [7:0] div2_q, div2_d;             // Stage two counts
    logic [31:0] rdata_q, rdata_d;          // Read data for the data phase
    logic wrPend_q, wrPend_d;               // Write data phase pending
    logic [7:0] wrAddr_q, wrAddr_d;         // Address of the pending write
    logic [31:0] stat_q, stat_d;            // Status snapshot
    logic addrPhase;                        // Transfer taken this cycle
    logic [7:0] a8;                         // Word-aligned low address bits
    logic balanceOn;                        // Duty balance active
    logic prescUsed;                        // Prescaler in the path
    logic [CNT_W-1:0] pN, pM;               // Prescaler high and low fields
    logic [NUM_STAGES-1:0] stByp;           // Bypass per stage
    logic [CNT_W-1:0] stN [NUM_STAGES];     // High field per stage
    logic [CNT_W-1:0] stM [NUM_STAGES];     // Low field per stage
    logic [NUM_STAGES-1:0] stHalf;          // Half-cycle stretch per stage
    logic [5:0] d1, d2;                     // Stage divisions
    logic [10:0] chanDiv;                   // Channel division
    logic cfgOk;                            // Counts meet balance conditions
    logic allByp;                           // Every divider bypassed
    logic run;                              // Output enabled

    ddc_link_if lnk [NUM_STAGES+1] ();

    // Source of the chain: one tick each core cycle, period of one cycle
    assign lnk[0].tick = 1'b1;
    assign lnk[0].level = 1'b1;
    assign lnk[0].period = 13'h0001;

    // Disable bit low means balance on
    assign balanceOn = !ctrl_q[CTRL_BAL_DIS];
    assign run = ctrl_q[CTRL_RUN];
    assign prescUsed = presc_q >= PRESC_MIN && presc_q <= PRESC_MAX;
    // Prescaler high is the lower half, so three gives a third, five two fifths
    assign pN = prescUsed ? CNT_W'((presc_q >> 1) - 3'h1) : 4'h0;
    assign pM = prescUsed ? CNT_W'(presc_q - (presc_q >> 1) - 3'h1) : 4'h0;

    assign stByp = {ctrl_q[CTRL_BYP2], ctrl_q[CTRL_BYP1], !prescUsed};
    assign stN[0] = pN;
    assign stM[0] = pM;
    assign stN[1] = div1_q[FLD_N_LSB +: CNT_W];
    assign stM[1] = div1_q[FLD_M_LSB +: CNT_W];
    assign stN[2] = div2_q[FLD_N_LSB +: CNT_W];
    assign stM[2] = div2_q[FLD_M_LSB +: CNT_W];

    // Prescaler, stage one, stage two in cascade; last active stage sets duty
    for (genvar g = 0; g < NUM_STAGES; g++) begin : g_stage
        ddc_stage u_stage (
            .core_clk(core_clk),
            .arst_n(arst_n),
            .clkEn(clkEn),
            .balanceOn(balanceOn),
            .bypass(stByp[g]),
            .nHigh(stN[g]),
            .mLow(stM[g]),
            .up(lnk[g]),
            .dn(lnk[g+1]),
            .halfOn(stHalf[g])
        );
    end

    // Channel division is the product of the two stages
    assign d1 = stage_div(ctrl_q[CTRL_BYP1], stN[1], stM[1]);
    assign d2 = stage_div(ctrl_q[CTRL_BYP2], stN[2], stM[2]);
    assign chanDiv = 11'({6'h00, d1} * {6'h00, d2});
    assign allByp = &stByp;

    // Direct path keeps the input clock's own duty when nothing divides
    assign clkOut = run && (allByp ? core_clk : lnk[NUM_STAGES].level);

    // Balance conditions checked for software
    always_comb begin
        cfgOk = 1'b1;
        if (balanceOn) begin
            if (!ctrl_q[CTRL_BYP1] && (d1[0] ? stM[1] != stN[1] + 4'h1 : stM[1] != stN[1])) begin
                cfgOk = 1'b0;
            end
            if (!ctrl_q[CTRL_BYP2] && (d2[0] ? stM[2] != stN[2] + 4'h1 : stM[2] != stN[2])) begin
                cfgOk = 1'b0;
            end
            if (ctrl_q[CTRL_BYP1] && !ctrl_q[CTRL_BYP2]) begin
                cfgOk = 1'b0;
            end
            if (!ctrl_q[CTRL_BYP1] && !ctrl_q[CTRL_BYP2] && !d1[0] && d2[0]) begin
                cfgOk = 1'b0;
            end
        end
    end

    // Bus slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    assign addrPhase = hsel && htrans[1] && hready;
    assign a8 = {haddr[7:2], 2'b00};

    // Next values of the registers and the bus pipeline
    always_comb begin
        ctrl_d = ctrl_q;
        presc_d = presc_q;
        div1_d = div1_q;
        div2_d = div2_q;
        wrPend_d = wrPend_q;
        wrAddr_d = wrAddr_q;
        rdata_d = rdata_q;
        stat_d = 32'h0000_0000;
        stat_d[STAT_LVL] = lnk[NUM_STAGES].level;
        stat_d[STAT_OK] = cfgOk;
        stat_d[STAT_DIV_LSB +: 11] = chanDiv;
        // Write data phase commits first so a following read sees it
        if (wrPend_q && hready) begin
            wrPend_d = 1'b0;
            if (wrAddr_q == ADDR_CTRL) begin
                ctrl_d = hwdata[CTRL_W-1:0];
            end else if (wrAddr_q == ADDR_PRESC) begin
                presc_d = hwdata[PRESC_W-1:0];
            end else if (wrAddr_q == ADDR_DIV1) begin
                div1_d = hwdata[7:0];
            end else if (wrAddr_q == ADDR_DIV2) begin
                div2_d = hwdata[7:0];
            end
        end
        if (addrPhase) begin
            wrPend_d = hwrite;
            wrAddr_d = a8;
            // Read value captured from the updated registers
            if (hwrite) begin
                rdata_d = 32'h0000_0000;
            end else if (a8 == ADDR_CTRL) begin
                rdata_d = {28'h000_0000, ctrl_d};
            end else if (a8 == ADDR_PRESC) begin
                rdata_d = {29'h0000_0000, presc_d};
            end else if (a8 == ADDR_DIV1) begin
                rdata_d = {24'h00_0000, div1_d};
            end else if (a8 == ADDR_DIV2) begin
                rdata_d = {24'h00_0000, div2_d};
            end else if (a8 == ADDR_STAT) begin
                rdata_d = stat_q;
            end else begin
                // Unmapped words read zero
                rdata_d = 32'h0000_0000;
            end
        end
    end

    // Register stage for configuration and bus state
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= CTRL_RST;
            presc_q <= PRESC_RST;
            div1_q <= DIV_RST;
            div2_q <= DIV_RST;
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
            stat_q <= 32'h0000_0000;
        end else if (clkEn) begin
            ctrl_q <= ctrl_d;
            presc_q <= presc_d;
            div1_q <= div1_d;
            div2_q <= div2_d;
            wrPend_q <= wrPend_d;
            wrAddr_q <= wrAddr_d;
            rdata_q <= rdata_d;
            stat_q <= stat_d;
        end
    end

    property p_no_prescaler_pass;
        @(posedge core_clk) disable iff (!arst_n)
        allByp && run |-> ##0 (clkOut == core_clk);
    endproperty
    a_no_prescaler_pass: assert property (p_no_prescaler_pass)
        else $error("output not following input clock when all bypassed");

    property p_presc_third;
        @(posedge core_clk) disable iff (!arst_n)
        presc_q == 3'h3 |-> pN == 4'h0 && pM == 4'h1;
    endproperty
    a_presc_third: assert property (p_presc_third)
        else $error("prescale three not one high two low");

    property p_odd_presc_half;
        @(posedge core_clk) disable iff (!arst_n)
        balanceOn && prescUsed && presc_q[0] |-> stHalf[0];
    endproperty
    a_odd_presc_half: assert property (p_odd_presc_half)
        else $error("odd prescale lacks half-cycle stretch");

    property p_even_no_half;
        @(posedge core_clk) disable iff (!arst_n)
        !ctrl_q[CTRL_BYP2] && !d2[0] |-> !stHalf[2];
    endproperty
    a_even_no_half: assert property (p_even_no_half)
        else $error("even last stage uses half-cycle stretch");

    property p_p3_odd1;
        @(posedge core_clk) disable iff (!arst_n)
        balanceOn && presc_q == 3'h3 && !ctrl_q[CTRL_BYP1] && d1[0] && ctrl_q[CTRL_BYP2]
        |-> stHalf[1] && lnk[1].period == 13'h0003;
    endproperty
    a_p3_odd1: assert property (p_p3_odd1)
        else $error("prescale three with odd stage one lacks stretch");

    property p_chan_div;
        @(posedge core_clk) disable iff (!arst_n)
        $past(arst_n) |->
        chanDiv <= 11'(DIV_MAX) && stat_q[STAT_DIV_LSB +: 11] == $past(chanDiv);
    endproperty
    a_chan_div: assert property (p_chan_div)
        else $error("channel division wrong or above limit");

    property p_balance_stat;
        @(posedge core_clk) disable iff (!arst_n)
        clkEn && balanceOn && !ctrl_q[CTRL_BYP1] && ctrl_q[CTRL_BYP2] && !d1[0]
        && stM[1] == stN[1] |=> stat_q[STAT_OK];
    endproperty
    a_balance_stat: assert property (p_balance_stat)
        else $error("valid even balanced setting flagged bad");
endmodule // ddc_top
`default_nettype wire

// ---- ddc_clk_src.sv ----
// Divider input clock source model: clean 50% clock at the core rate
`timescale 1ns/1ps
`default_nettype none
module ddc_clk_src #(
    // Half period in ns; 4 ns gives 125 MHz
    parameter real HALF_NS = 4.0
) (
    // Generated divider input clock
    output var logic core_clk
);
    // Start low so that the first edge seen is a rising one
    initial core_clk = 1'b0;
    // Equal halves, because the balanced ratios assume a clean input duty
    always #(HALF_NS) core_clk = ~core_clk;
endmodule // ddc_clk_src
`default_nettype wire

// ---- cascaded_divider_duty_correction_tb.sv ----
// Self-checking bench for the cascaded divider with duty balance
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin nCompared++; if ((got) !== (ex)) begin \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); badCount++; end end
module cascaded_divider_duty_correction_tb
    import ddc_pkg::*;
;
    // Clock, reset and enable
    logic core_clk;
    logic arst_n;
    logic clkEn;
    // Bus master side
    logic hsel;
    logic hwrite;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    wire hready = hreadyout; // Single slave drives the bus ready
    // Divided output and bench state
    logic clkOut;
    logic [31:0] rd;
    int badCount;
    int nCompared;
    int hi;
    int per;

    // Upstream clock source
    ddc_clk_src ddc_clk_src_inst (.core_clk(core_clk));

    // Block under test
    ddc_top ddc_top_inst (.core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .clkOut(clkOut));

    // Verdict and end of run, shared by the tests and the watchdog
    task summarize();
        $display("Compared %0d, wrong %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Wait for ready at a rising edge; bounded so a stuck slave cannot hang here
    task waitRdy();
        int k;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (hready !== 1'b1 && k < 64);
        // A slave that never answers counts as a mismatch
        if (hready !== 1'b1) badCount++;
    endtask

    // Single word write: address phase, then data phase
    task ahbWr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= 1'b1;
        htrans <= 2'h2;
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
    endtask

    // Single word read; data taken at the edge that ends the data phase
    task ahbRd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= 1'b0;
        htrans <= 2'h2;
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        waitRdy();
        d = hrdata;
    endtask

    // Count half cycles high and per period, skipping a few periods to settle
    task meas(output int h, output int p);
        int k;
        int rises;
        logic prev;
        h = 0;
        p = 0;
        k = 0;
        rises = 0;
        prev = clkOut;
        while (rises < 4 && k < 4000) begin
            @(core_clk);
            #1;
            k++;
            // Only the period from the third rise to the fourth is counted
            if (rises == 3) begin
                p++;
                if (clkOut === 1'b1) h++;
            end
            if (clkOut === 1'b1 && prev !== 1'b1) rises++;
            prev = clkOut;
        end
        // An output that stops toggling counts as a mismatch
        if (rises < 4) badCount++;
    endtask

    // Program one setup with run off first, then run and measure the duty
    task duty(input logic [3:0] c, input logic [2:0] p, input logic [7:0] d1,
              input logic [7:0] d2, input int eh, input int ep);
        ahbWr(ADDR_CTRL, 32'h00000000);
        ahbWr(ADDR_PRESC, {29'h0, p});
        ahbWr(ADDR_DIV1, {24'h0, d1});
        ahbWr(ADDR_DIV2, {24'h0, d2});
        ahbWr(ADDR_CTRL, {28'h0, c});
        meas(hi, per);
        `CHK("high halves", eh, hi)
        `CHK("period halves", ep, per)
    endtask

    // Watchdog: the whole sequence needs well under this span
    initial begin
        #400000;
        badCount++;
        summarize();
    end

    // Main sequence
    initial begin
        badCount = 0;
        nCompared = 0;
        arst_n = 1'b0;
        clkEn = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        // Reset values, an unmapped word, and a quiet output while run is off
        ahbRd(ADDR_CTRL, rd);
        `CHK("ctrl reset", 32'h00000006, rd)
        ahbRd(ADDR_PRESC, rd);
        `CHK("prescale reset", 32'h00000001, rd)
        ahbRd(ADDR_DIV1, rd);
        `CHK("stage one reset", 32'h00000000, rd)
        ahbWr(8'h14, 32'hFFFFFFFF);
        ahbRd(8'h14, rd);
        `CHK("unmapped word", 32'h00000000, rd)
        `CHK("idle output", 1'b0, clkOut)
        `CHK("bus ready", 1'b1, hreadyout)
        `CHK("bus response", 1'b0, hresp)
        // Duty table: ctrl, prescale, stage one, stage two, high and period halves
        duty(4'hF, 3'h1, 8'h00, 8'h00, 1, 2);
        duty(4'hF, 3'h3, 8'h00, 8'h00, 2, 6);
        duty(4'hF, 3'h5, 8'h00, 8'h00, 4, 10);
        duty(4'hF, 3'h4, 8'h00, 8'h00, 4, 8);
        duty(4'hE, 3'h3, 8'h00, 8'h00, 3, 6);
        duty(4'hE, 3'h5, 8'h00, 8'h00, 5, 10);
        duty(4'hE, 3'h6, 8'h00, 8'h00, 6, 12);
        duty(4'hD, 3'h1, 8'h42, 8'h00, 6, 16);
        duty(4'hD, 3'h1, 8'h21, 8'h00, 4, 10);
        duty(4'hC, 3'h1, 8'h21, 8'h00, 5, 10);
        duty(4'hC, 3'h3, 8'h10, 8'h00, 9, 18);
        duty(4'hC, 3'h3, 8'h11, 8'h00, 12, 24);
        duty(4'h8, 3'h1, 8'h10, 8'h10, 9, 18);
        duty(4'h8, 3'h1, 8'h10, 8'h11, 12, 24);
        duty(4'h9, 3'h1, 8'h11, 8'h20, 8, 32);
        // Enable low freezes the divider: the output holds for longer than a period
        @(posedge core_clk);
        clkEn <= 1'b0;
        @(posedge core_clk);
        #1;
        rd[0] = clkOut;
        repeat (20) begin
            @(posedge core_clk);
            `CHK("frozen output", rd[0], clkOut)
        end
        clkEn <= 1'b1;
        // Status: channel division is the stage product
        ahbRd(ADDR_STAT, rd);
        `CHK("division", 11'h010, rd[12:2])
        ahbWr(ADDR_DIV1, 32'h000000FF);
        ahbWr(ADDR_DIV2, 32'h000000FF);
        ahbRd(ADDR_STAT, rd);
        `CHK("largest division", 11'h400, rd[12:2])
        // Status: balance conditions met, then broken by each software duty
        ahbWr(ADDR_DIV1, 32'h00000010);
        ahbWr(ADDR_DIV2, 32'h00000011);
        ahbWr(ADDR_CTRL, 32'h00000008);
        ahbRd(ADDR_STAT, rd);
        `CHK("balance ok", 1'b1, rd[1])
        ahbWr(ADDR_DIV1, 32'h00000011);
        ahbWr(ADDR_DIV2, 32'h00000010);
        ahbRd(ADDR_STAT, rd);
        `CHK("even stage one", 1'b0, rd[1])
        // Even second stage, so only the low-equals-high condition is broken
        ahbWr(ADDR_DIV2, 32'h00000011);
        ahbWr(ADDR_DIV1, 32'h00000020);
        ahbRd(ADDR_STAT, rd);
        `CHK("low not high", 1'b0, rd[1])
        ahbWr(ADDR_DIV1, 32'h00000011);
        ahbRd(ADDR_STAT, rd);
        `CHK("even balanced", 1'b1, rd[1])
        ahbWr(ADDR_DIV1, 32'h00000030);
        ahbRd(ADDR_STAT, rd);
        `CHK("odd low too long", 1'b0, rd[1])
        ahbWr(ADDR_CTRL, 32'h0000000A);
        ahbRd(ADDR_STAT, rd);
        `CHK("stage one bypassed", 1'b0, rd[1])
        summarize();
    end
endmodule // cascaded_divider_duty_correction_tb
`default_nettype wire
